//--- pkg/match_entry_params.svh
/*
  Constants of the match entry: field widths, reset values, tcp flag bit positions.
  Assumes inclusion by bare name from the design files.
*/
`ifndef MATCH_ENTRY_PARAMS_SVH
`define MATCH_ENTRY_PARAMS_SVH

`define ME_PORT_W        16
`define ME_ETYPE_W       16
`define ME_PORT_RST      16'h0000
`define ME_ETYPE_RST     16'h0600
`define ME_FLAG_FIN      0
`define ME_FLAG_SYN      1
`define ME_FLAG_RST      2
`define ME_FLAG_PSH      3
`define ME_FLAG_ACK      4
`define ME_FLAG_URG      5
`define ME_NUM_FLAGS     6

`endif

//--- pkg/match_entry_pkg.sv
/*
  Types of the match entry: port filter modes, flag settings, frame class.
  Assumes nothing of its surroundings.
*/
package match_entry_pkg;

  // port criterion mode
  typedef enum logic [1:0] {
    PORT_ANY   = 2'h0,
    PORT_EXACT = 2'h1,
    PORT_RANGE = 2'h2
  } port_mode_t;

  // tcp flag tri-state setting
  typedef enum logic [1:0] {
    FLAG_ANY   = 2'h0,
    FLAG_CLEAR = 2'h1,
    FLAG_SET   = 2'h2
  } flag_mode_t;

  // frame class of the entry
  typedef enum logic [1:0] {
    CLASS_ANY   = 2'h0,
    CLASS_ETYPE = 2'h1,
    CLASS_IP    = 2'h2
  } frame_class_t;

  // ethertype criterion mode
  typedef enum logic {
    ETYPE_ANY   = 1'h0,
    ETYPE_EXACT = 1'h1
  } etype_mode_t;

endpackage

//--- core/port_filter.sv
/*
  One tcp/udp port criterion: any, exact value or inclusive range.
  Assumes settings are held stable by the caller; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "match_entry_params.svh"

module port_filter #(
  parameter int PORT_W = `ME_PORT_W
) (
  input  wire  match_entry_pkg::port_mode_t i_mode,
  input  wire  logic [PORT_W-1:0]           i_value,
  input  wire  logic [PORT_W-1:0]           i_low,
  input  wire  logic [PORT_W-1:0]           i_high,
  input  wire  logic                        i_l4,
  input  wire  logic [PORT_W-1:0]           i_port,
  output logic                              o_pass
);

  // decide pass; non tcp/udp frames fail any mode but any
  always_comb begin
    unique case (i_mode)
      match_entry_pkg::PORT_ANY:   o_pass = 1'b1;
      match_entry_pkg::PORT_EXACT: o_pass = i_l4 && (i_port == i_value);
      match_entry_pkg::PORT_RANGE: o_pass = i_l4 && (i_port >= i_low) && (i_port <= i_high);
      default:                     o_pass = 1'b0; // code 3 is illegal
    endcase
  end

endmodule // port_filter
`default_nettype wire

//--- core/match_entry.sv
/*
  Layer-4 and ethertype match logic of one access-control entry.
  Assumes parsed header fields arrive in one cycle with i_hdr_valid on the
  switch clock; configuration is presented on ports and taken on i_cfg_load.
*/
`timescale 1ns/1ps
`default_nettype none
`include "match_entry_params.svh"

// How it works
// - source port filter: any always passes, else exact or range on tcp/udp only
// - source exact mode passes only a 16-bit source port equal to the value
// - source range mode passes source ports within the configured bounds
// - destination port filter has the same any, exact and range modes
// - destination exact mode passes only an equal 16-bit destination port
// - destination range mode passes destination ports within the bounds
// - fin setting: 0 rejects fin set, 1 requires it, any ignores
// - syn setting: 0 rejects syn set, 1 requires it, any ignores
// - rst setting: 0 rejects rst set, 1 requires it, any ignores
// - psh setting: 0 rejects psh set, 1 requires it, any ignores
// - ack setting: 0 rejects ack set, 1 requires it, any ignores
// - urg setting: 0 rejects urg set, 1 requires it, any ignores
// - ethertype filter only counts when the entry class is ethertype
// - ethertype filter: any passes, exact passes only an equal ethertype
module match_entry #(
  parameter int PORT_W  = `ME_PORT_W,
  parameter int ETYPE_W = `ME_ETYPE_W
) (
  input  wire  logic                          i_clk_sys,
  input  wire  logic                          i_rst_b,
  // configuration, taken on i_cfg_load
  input  wire  logic                          i_cfg_load,
  input  wire  match_entry_pkg::frame_class_t i_cfg_class,
  input  wire  match_entry_pkg::port_mode_t   i_cfg_sp_mode,
  input  wire  logic [PORT_W-1:0]             i_cfg_sp_value,
  input  wire  logic [PORT_W-1:0]             i_cfg_sp_low,
  input  wire  logic [PORT_W-1:0]             i_cfg_sp_high,
  input  wire  match_entry_pkg::port_mode_t   i_cfg_dp_mode,
  input  wire  logic [PORT_W-1:0]             i_cfg_dp_value,
  input  wire  logic [PORT_W-1:0]             i_cfg_dp_low,
  input  wire  logic [PORT_W-1:0]             i_cfg_dp_high,
  input  wire  logic [11:0]                   i_cfg_flags,
  input  wire  match_entry_pkg::etype_mode_t  i_cfg_etype_mode,
  input  wire  logic [ETYPE_W-1:0]            i_cfg_etype,
  // parsed frame header
  input  wire  logic                          i_hdr_valid,
  input  wire  logic                          i_hdr_tcp,
  input  wire  logic                          i_hdr_udp,
  input  wire  logic [PORT_W-1:0]             i_hdr_sport,
  input  wire  logic [PORT_W-1:0]             i_hdr_dport,
  input  wire  logic [5:0]                    i_hdr_tcp_flags,
  input  wire  logic [ETYPE_W-1:0]            i_hdr_etype,
  // result
  output logic                                o_result_valid,
  output logic                                o_hit
);

  // active configuration snapshot
  match_entry_pkg::frame_class_t cls;
  match_entry_pkg::port_mode_t   sp_mode;
  match_entry_pkg::port_mode_t   dp_mode;
  match_entry_pkg::etype_mode_t  et_mode;
  logic [PORT_W-1:0]             sp_value, sp_low, sp_high;
  logic [PORT_W-1:0]             dp_value, dp_low, dp_high;
  logic [11:0]                   flags;
  logic [ETYPE_W-1:0]            etype;

  match_entry_pkg::frame_class_t next_cls;
  match_entry_pkg::port_mode_t   next_sp_mode;
  match_entry_pkg::port_mode_t   next_dp_mode;
  match_entry_pkg::etype_mode_t  next_et_mode;
  logic [PORT_W-1:0]             next_sp_value, next_sp_low, next_sp_high;
  logic [PORT_W-1:0]             next_dp_value, next_dp_low, next_dp_high;
  logic [11:0]                   next_flags;
  logic [ETYPE_W-1:0]            next_etype;

  logic                          result_valid, hit;
  logic                          next_result_valid, next_hit;
  logic                          l4;
  logic                          sp_pass, dp_pass, flag_pass, et_pass;

  // tri-state flag check; clear rejects a set bit, set requires it
  function automatic logic flag_ok(input logic [1:0] mode, input logic bit_in);
    unique case (mode)
      match_entry_pkg::FLAG_CLEAR: flag_ok = !bit_in;
      match_entry_pkg::FLAG_SET:   flag_ok = bit_in;
      default:                     flag_ok = 1'b1;
    endcase
  endfunction

  // all fields replace together on one load, frames see old or new only
  always_comb begin
    next_cls      = cls;
    next_sp_mode  = sp_mode;
    next_sp_value = sp_value;
    next_sp_low   = sp_low;
    next_sp_high  = sp_high;
    next_dp_mode  = dp_mode;
    next_dp_value = dp_value;
    next_dp_low   = dp_low;
    next_dp_high  = dp_high;
    next_flags    = flags;
    next_et_mode  = et_mode;
    next_etype    = etype;
    if (i_cfg_load) begin
      next_cls      = i_cfg_class;
      next_sp_mode  = i_cfg_sp_mode;
      next_sp_value = i_cfg_sp_value;
      next_sp_low   = i_cfg_sp_low;
      next_sp_high  = i_cfg_sp_high;
      next_dp_mode  = i_cfg_dp_mode;
      next_dp_value = i_cfg_dp_value;
      next_dp_low   = i_cfg_dp_low;
      next_dp_high  = i_cfg_dp_high;
      next_flags    = i_cfg_flags;
      next_et_mode  = i_cfg_etype_mode;
      next_etype    = i_cfg_etype;
    end
  end

  // configuration registers, reset to a match-everything entry
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cls      <= match_entry_pkg::CLASS_ANY;
      sp_mode  <= match_entry_pkg::PORT_ANY;
      sp_value <= `ME_PORT_RST;
      sp_low   <= `ME_PORT_RST;
      sp_high  <= `ME_PORT_RST;
      dp_mode  <= match_entry_pkg::PORT_ANY;
      dp_value <= `ME_PORT_RST;
      dp_low   <= `ME_PORT_RST;
      dp_high  <= `ME_PORT_RST;
      flags    <= 12'h000;
      et_mode  <= match_entry_pkg::ETYPE_ANY;
      etype    <= `ME_ETYPE_RST;
    end else begin
      cls      <= next_cls;
      sp_mode  <= next_sp_mode;
      sp_value <= next_sp_value;
      sp_low   <= next_sp_low;
      sp_high  <= next_sp_high;
      dp_mode  <= next_dp_mode;
      dp_value <= next_dp_value;
      dp_low   <= next_dp_low;
      dp_high  <= next_dp_high;
      flags    <= next_flags;
      et_mode  <= next_et_mode;
      etype    <= next_etype;
    end
  end

  assign l4 = i_hdr_tcp || i_hdr_udp;

  // source port criterion
  port_filter #(
    .PORT_W (PORT_W)
  ) u_sport (
    .i_mode  (sp_mode),
    .i_value (sp_value),
    .i_low   (sp_low),
    .i_high  (sp_high),
    .i_l4    (l4),
    .i_port  (i_hdr_sport),
    .o_pass  (sp_pass)
  );

  // destination port criterion
  port_filter #(
    .PORT_W (PORT_W)
  ) u_dport (
    .i_mode  (dp_mode),
    .i_value (dp_value),
    .i_low   (dp_low),
    .i_high  (dp_high),
    .i_l4    (l4),
    .i_port  (i_hdr_dport),
    .o_pass  (dp_pass)
  );

  // tcp flags, checked only on tcp frames
  always_comb begin
    flag_pass = 1'b1;
    if (i_hdr_tcp) begin
      flag_pass =
        flag_ok(flags[2*`ME_FLAG_FIN +: 2], i_hdr_tcp_flags[`ME_FLAG_FIN]) &&
        flag_ok(flags[2*`ME_FLAG_SYN +: 2], i_hdr_tcp_flags[`ME_FLAG_SYN]) &&
        flag_ok(flags[2*`ME_FLAG_RST +: 2], i_hdr_tcp_flags[`ME_FLAG_RST]) &&
        flag_ok(flags[2*`ME_FLAG_PSH +: 2], i_hdr_tcp_flags[`ME_FLAG_PSH]) &&
        flag_ok(flags[2*`ME_FLAG_ACK +: 2], i_hdr_tcp_flags[`ME_FLAG_ACK]) &&
        flag_ok(flags[2*`ME_FLAG_URG +: 2], i_hdr_tcp_flags[`ME_FLAG_URG]);
    end
  end

  // ethertype only for the ethertype class
  always_comb begin
    et_pass = 1'b1;
    if (cls == match_entry_pkg::CLASS_ETYPE
        && et_mode == match_entry_pkg::ETYPE_EXACT) begin
      et_pass = (i_hdr_etype == etype);
    end
  end

  // registered verdict, one cycle after the header
  always_comb begin
    next_result_valid = i_hdr_valid;
    next_hit          = i_hdr_valid && sp_pass && dp_pass && flag_pass && et_pass;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_valid <= 1'b0;
      hit          <= 1'b0;
    end else begin
      result_valid <= next_result_valid;
      hit          <= next_hit;
    end
  end

  assign o_result_valid = result_valid;
  assign o_hit          = hit;

endmodule // match_entry
`default_nettype wire

//--- verif/match_entry_assertions.sv
/*
  Checker of the match entry: result timing and verdicts against settings.
  Assumes a bind onto match_entry with its single switch clock.
*/
`timescale 1ns/1ps
`default_nettype none
module match_entry_assertions #(
  parameter int PORT_W  = 16,
  parameter int ETYPE_W = 16
) (
  input wire logic                          i_clk_sys,
  input wire logic                          i_rst_b,
  input wire logic                          i_cfg_load,
  input wire match_entry_pkg::frame_class_t i_cfg_class,
  input wire logic [11:0]                   i_cfg_flags,
  input wire match_entry_pkg::etype_mode_t  i_cfg_etype_mode,
  input wire logic [ETYPE_W-1:0]            i_cfg_etype,
  input wire logic                          i_hdr_valid,
  input wire logic                          i_hdr_tcp,
  input wire logic [5:0]                    i_hdr_tcp_flags,
  input wire logic [ETYPE_W-1:0]            i_hdr_etype,
  input wire logic                          o_result_valid,
  input wire logic                          o_hit
);
  logic [ETYPE_W+14:0] cfg, next_cfg; // class, flags, ethertype mode and value
  logic [5:0]          bad;
  // settings in force, taken on each load
  always_comb begin
    next_cfg = i_cfg_load ? {i_cfg_class, i_cfg_flags, i_cfg_etype_mode, i_cfg_etype} : cfg;
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end
  // tcp flags of this header that the settings forbid
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      bad[k] = i_hdr_valid && i_hdr_tcp
             && cfg[ETYPE_W+1+2*k +: 2] == {!i_hdr_tcp_flags[k], i_hdr_tcp_flags[k]};
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_result_next: assert property (i_hdr_valid |=> o_result_valid) else $error("no result");
  a_result_cause: assert property (o_result_valid |-> $past(i_hdr_valid))
    else $error("stray");
  a_hit_gated: assert property (o_hit |-> o_result_valid) else $error("hit alone");
  a_fin_rule: assert property (bad[0] |=> !o_hit) else $error("fin");
  a_syn_rule: assert property (bad[1] |=> !o_hit) else $error("syn");
  a_rst_rule: assert property (bad[2] |=> !o_hit) else $error("rst");
  a_psh_rule: assert property (bad[3] |=> !o_hit) else $error("psh");
  a_ack_rule: assert property (bad[4] |=> !o_hit) else $error("ack");
  a_urg_rule: assert property (bad[5] |=> !o_hit) else $error("urg");
  a_etype_miss: assert property (i_hdr_valid && cfg[ETYPE_W+14:ETYPE_W+13] == 2'h1
    && cfg[ETYPE_W] && i_hdr_etype != cfg[ETYPE_W-1:0] |=> !o_hit) else $error("etype");
  c_hit: cover property (o_hit);
  c_miss: cover property (o_result_valid && !o_hit);
  c_load_hdr: cover property (i_cfg_load && i_hdr_valid);
endmodule // match_entry_assertions
bind match_entry match_entry_assertions #(.PORT_W(PORT_W), .ETYPE_W(ETYPE_W)) chk_u (
  .i_clk_sys, .i_rst_b, .i_cfg_load, .i_cfg_class, .i_cfg_flags, .i_cfg_etype_mode,
  .i_cfg_etype, .i_hdr_valid, .i_hdr_tcp, .i_hdr_tcp_flags, .i_hdr_etype, .o_result_valid, .o_hit
);
`default_nettype wire

//--- verif/rx_path_model.sv
/*
  Receive path model: hands parsed headers {tcp, udp, sport, dport, flags, ethertype}.
  Assumes callers act at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_path_model (
  input  wire logic        i_clk_sys,
  output logic             o_hdr_valid,
  output logic [55:0]      o_hdr
);
  // nothing offered before the first header
  initial begin
    o_hdr_valid = 1'b0;
    o_hdr       = 56'h55_5555_5555_5555;
  end
  // offer one header for one cycle; back to back calls keep valid high
  task automatic put(input logic [55:0] h);
    o_hdr_valid = 1'b1;
    o_hdr       = h;
    @(negedge i_clk_sys);
  endtask
  // withdraw; fields invert so stale values never pass for a header
  task automatic idle();
    o_hdr_valid = 1'b0;
    o_hdr       = ~o_hdr;
    @(negedge i_clk_sys);
  endtask
endmodule // rx_path_model
`default_nettype wire

//--- verif/test_match_entry.sv
/*
  Testbench of the match entry: loads settings and sends headers.
  Assumes the receive path model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_match_entry;
  logic                          clk, rst_b, cfg_ld, hv, rv, hit;
  match_entry_pkg::frame_class_t cls;
  match_entry_pkg::port_mode_t   spm, dpm;
  match_entry_pkg::etype_mode_t  em;
  logic [15:0]                   spv, spl, sph, dpv, dpl, dph, ev;
  logic [11:0]                   fl;
  logic [55:0]                   hdr;
  int                            err_total, compares, n;

  match_entry dut_u (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_cfg_load(cfg_ld), .i_cfg_class(cls),
    .i_cfg_sp_mode(spm), .i_cfg_sp_value(spv), .i_cfg_sp_low(spl), .i_cfg_sp_high(sph),
    .i_cfg_dp_mode(dpm), .i_cfg_dp_value(dpv), .i_cfg_dp_low(dpl), .i_cfg_dp_high(dph),
    .i_cfg_flags(fl), .i_cfg_etype_mode(em), .i_cfg_etype(ev), .i_hdr_valid(hv),
    .i_hdr_tcp(hdr[55]), .i_hdr_udp(hdr[54]), .i_hdr_sport(hdr[53:38]),
    .i_hdr_dport(hdr[37:22]), .i_hdr_tcp_flags(hdr[21:16]), .i_hdr_etype(hdr[15:0]),
    .o_result_valid(rv), .o_hit(hit));
  rx_path_model rx_u (.i_clk_sys(clk), .o_hdr_valid(hv), .o_hdr(hdr));

  // free running switch clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count a compare and report a mismatch
  task automatic chk(input string nm, input logic s, input logic e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  // one header, verdict one cycle later
  task automatic fr(input logic [55:0] h, input logic e);
    rx_u.put(h);
    chk("result_valid", rv, 1'b1);
    chk("hit", hit, e);
  endtask
  // quiet header side, then a one cycle load
  task automatic load();
    rx_u.idle();
    cfg_ld = 1'b1;
    @(negedge clk);
    cfg_ld = 1'b0;
  endtask
  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (5000) @(negedge clk);
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    {rst_b, cfg_ld, spv, spl, sph, dpv, dpl, dph, fl} = '0;
    ev  = 16'h0600;
    cls = match_entry_pkg::CLASS_ANY;
    spm = match_entry_pkg::PORT_ANY;
    dpm = match_entry_pkg::PORT_ANY;
    em  = match_entry_pkg::ETYPE_ANY;
    err_total = 0;
    compares = 0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    fr({2'b00, 54'h0}, 1'b1);
    spm = match_entry_pkg::PORT_EXACT;
    spv = 16'h0050;
    load();
    fr({2'b10, 16'h0050, 38'h0}, 1'b1);
    fr({2'b01, 16'h0050, 38'h0}, 1'b1);
    fr({2'b10, 16'h0051, 38'h0}, 1'b0);
    fr({2'b00, 16'h0050, 38'h0}, 1'b0);
    spm = match_entry_pkg::PORT_RANGE;
    spl = 16'h000a;
    sph = 16'h0014;
    load();
    for (n = 9; n < 22; n++) fr({2'b10, 16'(n), 38'h0}, 1'(n >= 10 && n <= 20));
    spm = match_entry_pkg::PORT_ANY;
    dpm = match_entry_pkg::PORT_EXACT;
    dpv = 16'hffff;
    load();
    fr({2'b01, 16'h0, 16'hffff, 22'h0}, 1'b1);
    fr({2'b01, 16'h0, 16'hfffe, 22'h0}, 1'b0);
    dpm = match_entry_pkg::PORT_RANGE;
    dph = 16'h0003;
    load();
    for (n = 0; n < 5; n++) fr({2'b10, 16'h0, 16'(n), 22'h0}, 1'(n <= 3));
    dpm = match_entry_pkg::PORT_ANY;
    // each flag alone: must be clear, then must be set; udp ignores flags
    for (n = 0; n < 6; n++) begin
      fl = 12'h001 << (2 * n);
      load();
      fr({2'b10, 32'h0, 6'h01 << n, 16'h0}, 1'b0);
      fr({2'b10, 54'h0}, 1'b1);
      fl = 12'h002 << (2 * n);
      load();
      fr({2'b10, 54'h0}, 1'b0);
      fr({2'b10, 32'h0, 6'h01 << n, 16'h0}, 1'b1);
      fr({2'b01, 54'h0}, 1'b1);
    end
    fl = 12'h000;
    cls = match_entry_pkg::CLASS_ETYPE;
    em = match_entry_pkg::ETYPE_EXACT;
    ev = 16'h88cc;
    load();
    fr({2'b00, 38'h0, 16'h88cc}, 1'b1);
    fr({2'b00, 38'h0, 16'h88cd}, 1'b0);
    cls = match_entry_pkg::CLASS_IP;
    load();
    fr({2'b00, 38'h0, 16'h88cd}, 1'b1);
    cls = match_entry_pkg::CLASS_ETYPE;
    em = match_entry_pkg::ETYPE_ANY;
    load();
    fr({2'b00, 38'h0, 16'h88cd}, 1'b1);
    // spare codes: flag code 3 ignores the bit, class 3 is not the ethertype class
    fl  = 12'hfff;
    cls = match_entry_pkg::frame_class_t'(2'h3);
    em  = match_entry_pkg::ETYPE_EXACT;
    load();
    fr({2'b10, 32'h0, 6'h3f, 16'h0}, 1'b1);
    // illegal port mode and an empty range never pass
    spm = match_entry_pkg::port_mode_t'(2'h3);
    load();
    fr({2'b01, 54'h0}, 1'b0);
    spm = match_entry_pkg::PORT_ANY;
    dpm = match_entry_pkg::PORT_RANGE;
    dpl = 16'h0005;
    dph = 16'h0004;
    load();
    fr({2'b01, 16'h0, 16'h0005, 22'h0}, 1'b0);
    fr({2'b01, 16'h0, 16'h0004, 22'h0}, 1'b0);
    // back to a match-everything entry
    dpm = match_entry_pkg::PORT_ANY;
    fl  = 12'h000;
    cls = match_entry_pkg::CLASS_ETYPE;
    em  = match_entry_pkg::ETYPE_ANY;
    load();
    // load and header in one cycle: header still sees the old settings
    spm = match_entry_pkg::PORT_EXACT;
    spv = 16'h0005;
    cfg_ld = 1'b1;
    fr({2'b10, 16'h0006, 38'h0}, 1'b1);
    cfg_ld = 1'b0;
    fr({2'b10, 16'h0006, 38'h0}, 1'b0);
    rx_u.idle();
    chk("result_valid", rv, 1'b0);
    print_verdict();
  end
endmodule // test_match_entry
`default_nettype wire
